/* File: design/asp_consts.vh */
// constants for the asynchronous serial port
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
// line-setting word layout
`define ASP_PERIOD_MSB 12
`define ASP_BIT_7BIT 13
`define ASP_BIT_INV 14
`define ASP_BIT_OPEN 15
`define ASP_MODE_MAX 16'hecf1
`define ASP_PERIOD_OFS 20
// APB register byte offsets
`define ASP_REG_MODE 8'h00
`define ASP_REG_CTRL 8'h04
`define ASP_REG_PACE 8'h08
`define ASP_REG_TMO 8'h0c
`define ASP_REG_TXD 8'h10
`define ASP_REG_RXD 8'h14
`define ASP_REG_STAT 8'h18
`define ASP_REG_QUAL0 8'h1c
`define ASP_REG_QUAL1 8'h20
// control bits
`define ASP_CTRL_FLOW_EN 0
`define ASP_CTRL_DEC 1
`define ASP_CTRL_RX_EN 2
`define ASP_CTRL_QLEN_LSB 4
// timing
`define ASP_CLK_HZ 25000000
`define ASP_US_PER_MS 1000
`define ASP_CYC_PER_US (`ASP_CLK_HZ / 1000000)
`define ASP_CYC_PER_MS (`ASP_CYC_PER_US * `ASP_US_PER_MS)
`define ASP_MODE_RESET 16'h018c
`endif

/* File: design/asp_serial_port.v */
// asynchronous serial transmit/receive unit with APB register access
// ----------------------------------------------------------------
// Summary of operation
// - bit period is field plus twenty microseconds
// - any period between slowest and fastest rate
// - mode word has 7-bit, invert, open bits
// - 4000h inverts, 8000h opens, C000h both
// - mode values above maximum are refused
// - pace gap between bytes without flow
// - flow wait times out and drops message
// - flow pin one of sixteen, data seventeen
// - no timeout means receiver waits forever
// - decimal formatter sends up to five digits
// - receive wait timeout in milliseconds flagged
// - receive parity checked, error flagged
// - capture held until qualifier bytes match
// ----------------------------------------------------------------
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.vh"
module asp_serial_port
(
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] gp_in,
    input wire ser_rx_in,
    output reg [16:0] pin_out,
    output reg [16:0] pin_oe
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [15:0] mode_r;
    reg [7:0] ctrl_r;
    reg [4:0] tx_pin_r;
    reg [4:0] rx_pin_r;
    reg [3:0] flow_pin_r;
    reg [15:0] pace_r;
    reg [15:0] tmo_r;
    reg [47:0] qual_r;
    reg [7:0] rx_data_r;
    reg rx_valid_r, rx_perr_r, rx_tmo_r, tx_tmo_r;
    wire wr = psel & penable & pwrite;
    wire rd_ok = (paddr <= `ASP_REG_QUAL1) && (paddr[1:0] == 2'b00);
    wire bad_mode = pwdata[15:0] > `ASP_MODE_MAX;
    wire tx_busy;
    wire tx_load = wr && paddr == `ASP_REG_TXD && !tx_busy;
    assign pready = 1'b1;
    // refused: unmapped, txd while busy, out-of-range mode
    assign pslverr = psel & penable & (!rd_ok | (pwrite & paddr == `ASP_REG_TXD & tx_busy)
        | (pwrite & paddr == `ASP_REG_MODE & bad_mode));
    wire [15:0] per_us = {3'h0, mode_r[`ASP_PERIOD_MSB:0]} + 16'd`ASP_PERIOD_OFS;
    wire inv = mode_r[`ASP_BIT_INV];
    wire opn = mode_r[`ASP_BIT_OPEN];
    wire is7 = mode_r[`ASP_BIT_7BIT];
    // ----------------------------------------------------------------
    // microsecond and millisecond ticks
    // ----------------------------------------------------------------
    reg [4:0] us_cnt_r;
    reg [9:0] ms_cnt_r;
    wire us_tick = us_cnt_r == 5'd24;
    wire ms_tick = us_tick && ms_cnt_r == 10'd999;
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            us_cnt_r <= 5'h00;
            ms_cnt_r <= 10'h000;
        end
        else
        begin
            us_cnt_r <= us_tick ? 5'h00 : us_cnt_r + 5'h01;
            if (us_tick)
                ms_cnt_r <= (ms_cnt_r == 10'd999) ? 10'h000 : ms_cnt_r + 10'h001;
        end
    end
    // ----------------------------------------------------------------
    // pin synchronisers: three stages, change when stages 2 and 3 agree
    // ----------------------------------------------------------------
    reg [16:0] s1_r, s2_r, s3_r, pin_q_r;
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_r <= 17'h1ffff;
            s2_r <= 17'h1ffff;
            s3_r <= 17'h1ffff;
            pin_q_r <= 17'h1ffff;
        end
        else
        begin
            s1_r <= {ser_rx_in, gp_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_q_r <= (s2_r & s3_r) | (pin_q_r & (s2_r | s3_r));
        end
    end
    wire flow_ok = pin_q_r[flow_pin_r] ^ inv;
    wire rx_line = pin_q_r[rx_pin_r] ^ inv;
    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    localparam TX_IDLE = 3'd0, TX_FLOW = 3'd1, TX_BIT = 3'd2, TX_PACE = 3'd3, TX_DIG = 3'd4;
    reg [2:0] tx_st_r;
    reg [10:0] tx_sh_r;
    reg [3:0] tx_n_r;
    reg [15:0] us_left_r, ms_left_r;
    reg [15:0] dec_val_r;
    reg [2:0] dig_n_r;
    reg [39:0] dig_r;
    reg tx_lvl_r;
    assign tx_busy = tx_st_r != TX_IDLE;
    // 16-bit value split into five decimal digits, msb first
    wire [15:0] d4 = dec_val_r / 16'd10000;
    wire [15:0] r4 = dec_val_r % 16'd10000;
    wire [15:0] d3 = r4 / 16'd1000;
    wire [15:0] r3 = r4 % 16'd1000;
    wire [15:0] d2 = r3 / 16'd100;
    wire [15:0] r2 = r3 % 16'd100;
    wire [15:0] d1 = r2 / 16'd10;
    wire [15:0] d0 = r2 % 16'd10;
    wire [2:0] ndig = (dec_val_r >= 16'd10000) ? 3'd5 : (dec_val_r >= 16'd1000) ? 3'd4 :
        (dec_val_r >= 16'd100) ? 3'd3 : (dec_val_r >= 16'd10) ? 3'd2 : 3'd1;
    wire [7:0] ch = is7 ? {1'b0, dig_r[38:32]} : dig_r[39:32];
    wire [10:0] frame = is7 ? {1'b1, ^ch[6:0], ch[6:0], 1'b0, 1'b1}
        : {1'b1, 1'b1, ch, 1'b0};
    wire [3:0] nbits = is7 ? 4'd10 : 4'd10;
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            tx_st_r <= TX_IDLE;
            tx_sh_r <= 11'h7ff;
            tx_n_r <= 4'h0;
            us_left_r <= 16'h0000;
            ms_left_r <= 16'h0000;
            dec_val_r <= 16'h0000;
            dig_n_r <= 3'h0;
            dig_r <= 40'h0;
            tx_lvl_r <= 1'b1;
            tx_tmo_r <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `ASP_REG_STAT && pwdata[3])
                tx_tmo_r <= 1'b0;
            case (tx_st_r)
                TX_IDLE:
                    if (tx_load)
                    begin
                        dec_val_r <= pwdata[15:0];
                        dig_r <= {pwdata[7:0], 32'h0};
                        dig_n_r <= 3'd1;
                        ms_left_r <= tmo_r;
                        tx_st_r <= ctrl_r[`ASP_CTRL_DEC] ? TX_DIG : TX_FLOW;
                    end
                TX_DIG:
                begin
                    dig_r <= {d4[7:0] | 8'h30, d3[7:0] | 8'h30, d2[7:0] | 8'h30,
                        d1[7:0] | 8'h30, d0[7:0] | 8'h30} << (6'd8 * (6'd5 - {3'h0, ndig}));
                    dig_n_r <= ndig;
                    tx_st_r <= TX_FLOW;
                end
                TX_FLOW:
                    if (!ctrl_r[`ASP_CTRL_FLOW_EN] || flow_ok)
                    begin
                        tx_sh_r <= is7 ? {1'b1, frame[10:1]} : frame;
                        tx_n_r <= nbits;
                        us_left_r <= per_us;
                        tx_lvl_r <= 1'b0;
                        tx_st_r <= TX_BIT;
                    end
                    else if (ms_tick && tmo_r != 16'h0)
                    begin
                        if (ms_left_r <= 16'h0001)
                        begin
                            tx_tmo_r <= 1'b1;
                            tx_st_r <= TX_IDLE;
                        end
                        else
                            ms_left_r <= ms_left_r - 16'h0001;
                    end
                TX_BIT:
                    if (us_tick)
                    begin
                        if (us_left_r > 16'h0001)
                            us_left_r <= us_left_r - 16'h0001;
                        else if (tx_n_r > 4'h1)
                        begin
                            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                            tx_lvl_r <= tx_sh_r[1];
                            tx_n_r <= tx_n_r - 4'h1;
                            us_left_r <= per_us;
                        end
                        else
                        begin
                            tx_lvl_r <= 1'b1;
                            dig_r <= {dig_r[31:0], 8'h00};
                            dig_n_r <= dig_n_r - 3'h1;
                            // with flow control the next digit waits afresh for go-ahead
                            ms_left_r <= ctrl_r[`ASP_CTRL_FLOW_EN] ? tmo_r : pace_r;
                            if (dig_n_r == 3'h1)
                                tx_st_r <= TX_IDLE;
                            else
                                tx_st_r <= ctrl_r[`ASP_CTRL_FLOW_EN] ? TX_FLOW : TX_PACE;
                        end
                    end
                TX_PACE:
                    if (ms_left_r == 16'h0)
                    begin
                        ms_left_r <= tmo_r;
                        tx_st_r <= TX_FLOW;
                    end
                    else if (ms_tick)
                        ms_left_r <= ms_left_r - 16'h0001;
                default:
                    tx_st_r <= TX_IDLE;
            endcase
        end
    end
    // invert and open-drain output stage
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            pin_out <= 17'h0;
            pin_oe <= 17'h0;
        end
        else
        begin
            pin_out <= 17'h0;
            pin_oe <= 17'h0;
            pin_out[tx_pin_r] <= tx_lvl_r ^ inv;
            // open output drives only the active (start/space) level
            pin_oe[tx_pin_r] <= opn ? !tx_lvl_r : 1'b1;
        end
    end
    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    localparam RX_IDLE = 2'd0, RX_BIT = 2'd1;
    reg [1:0] rx_st_r;
    reg [8:0] rx_sh_r;
    reg [3:0] rx_n_r;
    reg [15:0] rx_us_r, rx_ms_r;
    reg [2:0] q_idx_r;
    wire [2:0] qlen = ctrl_r[`ASP_CTRL_QLEN_LSB +: 3];
    wire [7:0] q_byte = qual_r[{q_idx_r, 3'b000} +: 8];
    wire [7:0] rx_byte = is7 ? {1'b0, rx_sh_r[7:1]} : rx_sh_r[8:1];
    wire rx_par_bad = is7 && (^rx_sh_r[7:1] != rx_sh_r[8]);
    wire clr_stat = wr && paddr == `ASP_REG_STAT;
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= 9'h0;
            rx_n_r <= 4'h0;
            rx_us_r <= 16'h0;
            rx_ms_r <= 16'h0;
            q_idx_r <= 3'h0;
            rx_data_r <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_perr_r <= 1'b0;
            rx_tmo_r <= 1'b0;
        end
        else
        begin
            if (clr_stat && pwdata[0])
                rx_valid_r <= 1'b0;
            if (clr_stat && pwdata[1])
                rx_perr_r <= 1'b0;
            if (clr_stat && pwdata[2])
                rx_tmo_r <= 1'b0;
            if (!ctrl_r[`ASP_CTRL_RX_EN])
            begin
                rx_st_r <= RX_IDLE;
                rx_ms_r <= tmo_r;
                q_idx_r <= 3'h0;
            end
            else
            case (rx_st_r)
                RX_IDLE:
                    if (!rx_line)
                    begin
                        rx_us_r <= {1'b0, per_us[15:1]};
                        // seven data bits plus parity fill the same ten slots
                        rx_n_r <= 4'd10;
                        rx_st_r <= RX_BIT;
                    end
                    // zero timeout waits indefinitely
                    else if (ms_tick && tmo_r != 16'h0 && !rx_tmo_r)
                    begin
                        if (rx_ms_r <= 16'h0001)
                        begin
                            rx_tmo_r <= 1'b1;
                            q_idx_r <= 3'h0;
                            rx_ms_r <= tmo_r;
                        end
                        else
                            rx_ms_r <= rx_ms_r - 16'h0001;
                    end
                RX_BIT:
                    if (us_tick)
                    begin
                        if (rx_us_r > 16'h0001)
                            rx_us_r <= rx_us_r - 16'h0001;
                        else if (rx_n_r > 4'h1)
                        begin
                            rx_sh_r <= {rx_line, rx_sh_r[8:1]};
                            rx_n_r <= rx_n_r - 4'h1;
                            rx_us_r <= per_us;
                        end
                        else
                        begin
                            rx_st_r <= RX_IDLE;
                            rx_ms_r <= tmo_r;
                            if (rx_par_bad)
                                rx_perr_r <= 1'b1;
                            else if (q_idx_r < qlen)
                                q_idx_r <= (rx_byte == q_byte) ? q_idx_r + 3'h1 : 3'h0;
                            else
                            begin
                                rx_data_r <= rx_byte;
                                rx_valid_r <= 1'b1;
                            end
                        end
                    end
                default:
                    rx_st_r <= RX_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            mode_r <= `ASP_MODE_RESET;
            ctrl_r <= 8'h00;
            tx_pin_r <= 5'h10;
            rx_pin_r <= 5'h10;
            flow_pin_r <= 4'h0;
            pace_r <= 16'h0;
            tmo_r <= 16'h0;
            qual_r <= 48'h0;
        end
        else if (wr)
        begin
            case (paddr)
                `ASP_REG_MODE:
                    if (!bad_mode)
                        mode_r <= pwdata[15:0];
                `ASP_REG_CTRL:
                begin
                    ctrl_r <= pwdata[7:0];
                    flow_pin_r <= pwdata[11:8];
                    tx_pin_r <= (pwdata[16:12] > 5'd16) ? 5'd16 : pwdata[16:12];
                    rx_pin_r <= (pwdata[21:17] > 5'd16) ? 5'd16 : pwdata[21:17];
                end
                `ASP_REG_PACE: pace_r <= pwdata[15:0];
                `ASP_REG_TMO: tmo_r <= pwdata[15:0];
                `ASP_REG_QUAL0: qual_r[31:0] <= pwdata;
                `ASP_REG_QUAL1: qual_r[47:32] <= pwdata[15:0];
                default: ;
            endcase
        end
    end
    always @*
    begin
        case (paddr)
            `ASP_REG_MODE: prdata = {16'h0, mode_r};
            `ASP_REG_CTRL: prdata = {10'h0, rx_pin_r, tx_pin_r, flow_pin_r, ctrl_r};
            `ASP_REG_PACE: prdata = {16'h0, pace_r};
            `ASP_REG_TMO: prdata = {16'h0, tmo_r};
            `ASP_REG_RXD: prdata = {24'h0, rx_data_r};
            `ASP_REG_STAT: prdata = {27'h0, tx_busy, tx_tmo_r, rx_tmo_r, rx_perr_r, rx_valid_r};
            `ASP_REG_QUAL0: prdata = qual_r[31:0];
            `ASP_REG_QUAL1: prdata = {16'h0, qual_r[47:32]};
            default: prdata = 32'h0;
        endcase
    end
endmodule // asp_serial_port
`default_nettype wire

/* File: tb/asp_props.sv */
// pin and apb checks for the serial port
`timescale 1ns/1ps
`default_nettype none
module asp_props
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [16:0] pin_out,
    input wire logic [16:0] pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [15:0] mode_r;
    logic ln;
    logic ln_d;
    logic acc;
    logic [19:0] run_r;
    assign acc = psel && penable;
    // a floating pin reads high through the pull-up
    assign ln = pin_oe[16] ? pin_out[16] : 1'b1;
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            mode_r <= 16'h018c;
            ln_d <= 1'b1;
            run_r <= 20'h00000;
        end
        else
        begin
            if (acc && pwrite && paddr == 8'h00 && !pslverr)
                mode_r <= pwdata[15:0];
            ln_d <= ln;
            run_r <= (ln != ln_d) ? 20'h00001 : run_r + 20'h00001;
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_rel;
        $rose(resetn);
    endsequence
    sequence s_wmode;
        acc && pwrite && paddr == 8'h00;
    endsequence
    property p_rel;
        s_rel |-> (pin_oe == 17'h00000) ##1 (pin_oe == 17'h10000 && pin_out[16]);
    endproperty
    property p_rdy;
        acc |-> pready;
    endproperty
    property p_unmap;
        acc && paddr > 8'h20 |-> pslverr;
    endproperty
    property p_align;
        acc && paddr[1:0] != 2'b00 |-> pslverr;
    endproperty
    property p_mode_big;
        (s_wmode ##0 (pwdata > 32'h0000ecf1)) |-> pslverr;
    endproperty
    property p_mode_ok;
        (s_wmode ##0 (pwdata <= 32'h0000ecf1)) |-> !pslverr;
    endproperty
    property p_one;
        $onehot0(pin_oe);
    endproperty
    // open output only ever drives the active level
    property p_open;
        mode_r[15] && mode_r == $past(mode_r, 2) && pin_oe[16] |-> pin_out[16] == mode_r[14];
    endproperty
    // an active-level run is never shorter than one bit, less one microsecond
    property p_bit;
        (ln != ln_d) && (ln_d == mode_r[14])
            |-> run_r >= ({7'h00, mode_r[12:0]} + 20'h00014) * 20'h00019 - 20'h00019;
    endproperty
    a_rel: assert property (p_rel) else $error("tx pin not idle after reset");
    a_rdy: assert property (p_rdy) else $error("pready low");
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    a_align: assert property (p_align) else $error("misaligned access accepted");
    a_mode_big: assert property (p_mode_big) else $error("mode above max accepted");
    a_mode_ok: assert property (p_mode_ok) else $error("valid mode refused");
    a_one: assert property (p_one) else $error("more than one pin enabled");
    a_open: assert property (p_open) else $error("open output drove idle");
    a_bit: assert property (p_bit) else $error("bit shorter than period");
endmodule // asp_props
bind asp_serial_port asp_props u_props (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

/* File: tb/asp_far_end.sv */
// far serial device: frame receiver, frame sender, flow pin
`timescale 1ns/1ps
`default_nettype none
module asp_far_end
(
    input wire logic clk,
    input wire logic line,
    output var logic rx_line,
    output var logic flow
);
    initial
    begin
        rx_line = 1'b1;
        flow = 1'b0;
    end
    task go(input logic v);
        flow <= v;
    endtask
    // eight slots after start; in 7-bit mode the last is parity
    task recv(input integer p, input logic inv, output logic [7:0] b, output logic ok);
        integer n;
        integer i;
        begin
            ok = 1'b1;
            n = 0;
            b = 8'h00;
            while (line !== inv && n < 40000)
            begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 40000)
                ok = 1'b0;
            repeat (p / 2) @(negedge clk);
            if (line !== inv)
                ok = 1'b0;
            for (i = 0; i < 8; i = i + 1)
            begin
                repeat (p) @(negedge clk);
                b[i] = line ^ inv;
            end
            repeat (p) @(negedge clk);
            if (line !== ~inv)
                ok = 1'b0;
        end
    endtask
    task send(input logic [7:0] b, input logic inv, input integer p);
        integer i;
        begin
            @(posedge clk);
            rx_line <= inv;
            repeat (p) @(posedge clk);
            for (i = 0; i < 8; i = i + 1)
            begin
                rx_line <= b[i] ^ inv;
                repeat (p) @(posedge clk);
            end
            rx_line <= ~inv;
            repeat (p) @(posedge clk);
        end
    endtask
endmodule // asp_far_end
`default_nettype wire

/* File: tb/async_serial_port_bench.sv */
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.vh"
module async_serial_port_bench;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e; logic bad; logic [31:0] rb;} asp_row_t;
    logic clk;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic [16:0] pin_out;
    wire logic [16:0] pin_oe;
    wire logic line;
    wire logic rx_line;
    wire logic flow;
    integer failures;
    integer checks;
    integer i;
    logic [31:0] q;
    logic e;
    asp_row_t rows [0:7];
    assign line = pin_oe[16] ? pin_out[16] : 1'b1;
    asp_serial_port DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gp_in({14'h0000, flow, 1'b0}), .ser_rx_in(rx_line),
        .pin_out(pin_out), .pin_oe(pin_oe));
    asp_far_end FAR (.clk(clk), .line(line), .rx_line(rx_line), .flow(flow));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task final_report;
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; answer taken at the edge pready is high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
        output logic re);
        integer n;
        logic r;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            r = 1'b0;
            while (r !== 1'b1)
            begin
                @(posedge clk);
                rq = prdata;
                re = pslverr;
                r = pready;
                n = n + 1;
                if (n > 50)
                begin
                    failures = failures + 1;
                    final_report;
                end
            end
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d, q, e);
        chk({31'h0, e}, {31'h0, ee});
    endtask
    // mode changes are kept apart from frames so every line run is whole
    task tx_chk(input logic [31:0] m, input logic [31:0] c, input logic [31:0] d,
        input integer nb, input logic [7:0] first);
        integer k;
        logic [7:0] b;
        logic ok;
        begin
            wr(`ASP_REG_MODE, m, 1'b0);
            repeat (600) @(posedge clk);
            wr(`ASP_REG_CTRL, c, 1'b0);
            fork
                for (k = 0; k < nb; k = k + 1)
                begin
                    FAR.recv((m[12:0] + 20) * 25, m[14], b, ok);
                    chk({24'h0, b}, {24'h0, first + k[7:0]});
                    chk({31'h0, ok}, 32'h1);
                end
                begin
                    wr(`ASP_REG_TXD, d, 1'b0);
                    wr(`ASP_REG_TXD, d, 1'b1);
                end
            join
            repeat (600) @(posedge clk);
        end
    endtask
    initial
    begin
        failures = 0;
        checks = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        rows[0] = '{8'h00, 32'h0000ecf1, 1'b0, 1'b0, 32'h0000ecf1};
        rows[1] = '{8'h00, 32'h0000ecf2, 1'b1, 1'b0, 32'h0000ecf1};
        rows[2] = '{8'h04, 32'h00011000, 1'b0, 1'b0, 32'h00010000};
        rows[3] = '{8'h24, 32'h00000001, 1'b1, 1'b1, 32'h00000000};
        rows[4] = '{8'h02, 32'h00000001, 1'b1, 1'b1, 32'h00000000};
        rows[5] = '{8'h00, 32'h00004000, 1'b0, 1'b0, 32'h00004000};
        rows[6] = '{8'h00, 32'h00008000, 1'b0, 1'b0, 32'h00008000};
        rows[7] = '{8'h00, 32'h0000c000, 1'b0, 1'b0, 32'h0000c000};
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (600) @(posedge clk);
        apb(1'b0, `ASP_REG_MODE, 32'h0, q, e);
        chk(q, 32'h0000018c);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(rows[i].a, rows[i].d, rows[i].e);
            apb(1'b0, rows[i].a, 32'h0, q, e);
            chk({31'h0, e}, {31'h0, rows[i].bad});
            if (!rows[i].bad)
                chk(q, rows[i].rb);
            repeat (600) @(posedge clk);
        end
        tx_chk(32'h8000, 32'h00210000, 32'h41, 1, 8'h41);
        tx_chk(32'h6000, 32'h00210000, 32'h31, 1, 8'hb1);
        tx_chk(32'h0, 32'h00210002, 32'h7b, 3, 8'h31);
        wr(`ASP_REG_TMO, 32'h1, 1'b0);
        wr(`ASP_REG_CTRL, 32'h00210105, 1'b0);
        wr(`ASP_REG_TXD, 32'h55, 1'b0);
        q = 32'h0;
        for (i = 0; i < 40 && q[3] !== 1'b1; i = i + 1)
        begin
            repeat (1000) @(posedge clk);
            apb(1'b0, `ASP_REG_STAT, 32'h0, q, e);
        end
        chk({31'h0, q[3]}, 32'h1);
        chk({31'h0, q[2]}, 32'h1);
        chk({31'h0, line}, 32'h1);
        wr(`ASP_REG_STAT, 32'h1f, 1'b0);
        FAR.go(1'b1);
        tx_chk(32'h0, 32'h00210101, 32'h55, 1, 8'h55);
        wr(`ASP_REG_TMO, 32'h0, 1'b0);
        wr(`ASP_REG_STAT, 32'h1f, 1'b0);
        wr(`ASP_REG_QUAL0, 32'h3c, 1'b0);
        wr(`ASP_REG_CTRL, 32'h00210014, 1'b0);
        repeat (600) @(posedge clk);
        FAR.send(8'h3c, 1'b0, 500);
        apb(1'b0, `ASP_REG_STAT, 32'h0, q, e);
        chk(q, 32'h0);
        FAR.send(8'ha5, 1'b0, 500);
        apb(1'b0, `ASP_REG_STAT, 32'h0, q, e);
        chk(q, 32'h1);
        apb(1'b0, `ASP_REG_RXD, 32'h0, q, e);
        chk(q, 32'ha5);
        wr(`ASP_REG_STAT, 32'h1f, 1'b0);
        wr(`ASP_REG_MODE, 32'h2000, 1'b0);
        repeat (600) @(posedge clk);
        FAR.send(8'h31, 1'b0, 500);
        apb(1'b0, `ASP_REG_STAT, 32'h0, q, e);
        chk({31'h0, q[1]}, 32'h1);
        // mid-run reset must bring back the power-up settings
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, `ASP_REG_CTRL, 32'h0, q, e);
        chk(q, 32'h00210000);
        apb(1'b0, `ASP_REG_MODE, 32'h0, q, e);
        chk(q, 32'h0000018c);
        apb(1'b0, `ASP_REG_STAT, 32'h0, q, e);
        chk(q, 32'h0);
        final_report;
    end
endmodule // async_serial_port_bench
`default_nettype wire
